// File: logic/are_regs.svh
// Constants of the adapter response reporter: characters, widths and timing.
// Assumes a single 125 MHz clock; included by its bare name.
`ifndef ARE_REGS_SVH
`define ARE_REGS_SVH

// Clock and time base
`define ARE_CLK_NS 8
`define ARE_MS_NS 1000000
`define ARE_MSDIV_W 17
`define ARE_GAP_W 15
`define ARE_GAP_MAX 15'h7FFF

// Response set and line shape
`define ARE_NRESP 11
`define ARE_POS_W 3
`define ARE_POS_FIRST 3'h0
`define ARE_POS_LAST 3'h4

// Characters of the response lines
`define ARE_CH_SLASH 8'h2F
`define ARE_CH_I 8'h49
`define ARE_CH_B 8'h42
`define ARE_CH_C 8'h43
`define ARE_CH_A 8'h41
`define ARE_CH_F 8'h46
`define ARE_CH_0 8'h30
`define ARE_CH_1 8'h31
`define ARE_CH_3 8'h33
`define ARE_CH_4 8'h34
`define ARE_CH_5 8'h35
`define ARE_CH_8 8'h38
`define ARE_CH_9 8'h39
`define ARE_CH_CR 8'h0D
`define ARE_CH_STAR 8'h2A

`endif

// File: logic/are_pkg.sv
// Types of the adapter response reporter.
// Assumes are_regs.svh for the numeric constants.
`default_nettype none
package are_pkg;
    // Response lines, lowest code sent first
    typedef enum logic [3:0] {
        RESP_ARB = 4'h0,
        RESP_BUSERR = 4'h1,
        RESP_BUSY = 4'h2,
        RESP_CLOSED = 4'h3,
        RESP_BADARG = 4'h4,
        RESP_NOSTR = 4'h5,
        RESP_BADCMD = 4'h6,
        RESP_OVFL = 4'h7,
        RESP_TIMEOUT = 4'h8,
        RESP_BAUD = 4'h9,
        RESP_READY = 4'hA
    } are_resp_t;

    // Kinds of decoded host command
    typedef enum logic [2:0] {
        CMD_MASTER = 3'h0,
        CMD_SLAVE_TEXT = 3'h1,
        CMD_OPEN = 3'h2,
        CMD_CLOSE = 3'h3,
        CMD_OTHER = 3'h4
    } are_cmd_t;

    // Serializer states
    typedef enum logic {
        SER_IDLE = 1'b0,
        SER_SEND = 1'b1
    } are_ser_t;
endpackage : are_pkg
`default_nettype wire

// File: logic/are_reporter.sv
// Response reporter of a serial-command I2C host adapter: decides host
// command replies, tracks connection and busy state, times byte gaps and
// sends coded response lines as a character stream.
// Assumes parser, transfer engines and serial transmitter on the same clock.
//
// Function
// R1 - When another master wins arbitration during a master transfer, abandon it and send /I83 with CR.
// R2 - After an arbitration-loss report the host handles slave events and then reissues the failed command.
// R3 - When a bus error is detected, send /I84 with CR.
// R4 - After a bus-error report the host retries or issues the adapter reset command.
// R5 - When the gap between bytes in a message exceeds the set time-out, send /I85.
// R6 - A time-out is only reported, with no action on the bus and no reply needed.
// R7 - A message operation asked for while the connection is closed is refused with /I88.
// R8 - The host opens the connection before any bus message operation.
// R9 - A command with an out-of-range argument is rejected with /I89.
// R10 - Slave-transmit text with no pending slave-transmit request is answered with /I8A.
// R11 - An unrecognised command is answered with /I8F.
// R12 - Loss of host data through receive overflow is reported with /I90.
// R13 - A link rate change is reported as /BCn, n being 0, 1 or 2 for 19.2K, 57.6K or 115.2K.
// R14 - A master operation started while one is in progress is ignored and answered with /I81.
// R15 - When ready for the next command, a single asterisk is sent.
// R16 - After any error line the block returns to idle reception with its configuration kept.
`include "are_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module are_reporter #(
    parameter int MS_CYCLES = `ARE_MS_NS / `ARE_CLK_NS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire are_pkg::are_cmd_t cmd_kind,
    input wire logic cmd_known,
    input wire logic cmd_arg_ok,
    input wire logic str_pending,
    input wire logic op_done,
    input wire logic arb_lost,
    input wire logic bus_error,
    input wire logic msg_active,
    input wire logic byte_done,
    input wire logic [`ARE_GAP_W-1:0] timeout_ms,
    input wire logic rx_overflow,
    input wire logic baud_change,
    input wire logic [1:0] baud_idx,
    input wire logic adapter_reset,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic master_start,
    output logic slave_text_go,
    output logic cmd_go,
    output logic abort_xfer,
    output logic conn_open,
    output logic busy
);
    import are_pkg::*;

    // Lowest pending code wins
    function automatic are_resp_t are_pick(input logic [`ARE_NRESP-1:0] p);
        are_resp_t r;
        r = RESP_READY;
        for (int i = `ARE_NRESP - 1; i >= 0; i--)
            if (p[i])
                r = are_resp_t'(i[3:0]);
        return r;
    endfunction : are_pick

    // Character at a position of a response line
    function automatic logic [7:0] are_char(input are_resp_t c, input logic [`ARE_POS_W-1:0] pos,
                                            input logic [1:0] bsel);
        logic [7:0] d;
        d = `ARE_CH_8;
        unique case (c)
            RESP_BUSY: d = `ARE_CH_1;
            RESP_ARB: d = `ARE_CH_3;
            RESP_BUSERR: d = `ARE_CH_4;
            RESP_TIMEOUT: d = `ARE_CH_5;
            RESP_CLOSED: d = `ARE_CH_8;
            RESP_BADARG: d = `ARE_CH_9;
            RESP_NOSTR: d = `ARE_CH_A;
            RESP_BADCMD: d = `ARE_CH_F;
            RESP_OVFL: d = `ARE_CH_0;
            RESP_BAUD: d = `ARE_CH_0 + {6'h00, bsel}; // see R13
            RESP_READY: d = `ARE_CH_STAR; // see R15
            default: d = `ARE_CH_8;
        endcase
        unique case (pos)
            3'h0: return (c == RESP_READY) ? d : `ARE_CH_SLASH; // see R15
            3'h1: return (c == RESP_BAUD) ? `ARE_CH_B : `ARE_CH_I;
            3'h2: return (c == RESP_BAUD) ? `ARE_CH_C : ((c == RESP_OVFL) ? `ARE_CH_9 : `ARE_CH_8);
            3'h3: return d;
            default: return `ARE_CH_CR;
        endcase
    endfunction : are_char

    logic [`ARE_NRESP-1:0] pend, set_v, clr_v;
    logic [1:0] baud_sel;
    are_ser_t state;
    are_resp_t cur;
    are_resp_t next_pick;
    logic [`ARE_POS_W-1:0] pos;
    logic [`ARE_MSDIV_W-1:0] ms_cnt;
    logic [`ARE_GAP_W-1:0] gap_ms;
    logic ms_tick, to_reported, to_fire, mcmd, scmd, master_ok, fault;

    // Command classification
    assign mcmd = cmd_valid && cmd_known && cmd_arg_ok && (cmd_kind == CMD_MASTER);
    assign scmd = cmd_valid && cmd_known && cmd_arg_ok && (cmd_kind == CMD_SLAVE_TEXT);
    assign master_ok = mcmd && conn_open && !busy;
    assign fault = busy && (arb_lost || bus_error);
    assign next_pick = are_pick(pend);

    // Events raising response lines
    always_comb
    begin
        set_v = '0;
        set_v[RESP_ARB] = arb_lost && busy; // see R1
        set_v[RESP_BUSERR] = bus_error; // see R3
        set_v[RESP_BUSY] = mcmd && conn_open && busy; // see R14
        set_v[RESP_CLOSED] = mcmd && !conn_open; // see R7
        set_v[RESP_BADARG] = cmd_valid && cmd_known && !cmd_arg_ok; // see R9
        set_v[RESP_NOSTR] = scmd && !str_pending; // see R10
        set_v[RESP_BADCMD] = cmd_valid && !cmd_known; // see R11
        set_v[RESP_OVFL] = rx_overflow; // see R12
        set_v[RESP_TIMEOUT] = to_fire; // see R5
        set_v[RESP_BAUD] = baud_change; // see R13
        // Prompt after each command reply or finished operation, and after an arbitration loss or bus error in a master operation
        set_v[RESP_READY] = (cmd_valid && !master_ok && !(scmd && str_pending)) || op_done
                            || fault; // see R15, R16
    end

    // Clear the code being taken by the serializer
    always_comb
    begin
        clr_v = '0;
        if (state == SER_IDLE && |pend)
            clr_v[next_pick] = 1'b1;
    end

    // Pending flags, a new event wins over the clear
    always_ff @(posedge clk)
    begin
        if (reset || adapter_reset)
            pend <= '0;
        else
            pend <= (pend & ~clr_v) | set_v;
    end

    // Latest link rate index
    always_ff @(posedge clk)
    begin
        if (reset)
            baud_sel <= 2'h0;
        else if (baud_change)
            baud_sel <= baud_idx; // see R13
    end

    // Connection state, untouched by rejected commands
    always_ff @(posedge clk)
    begin
        if (reset || adapter_reset)
            conn_open <= 1'b0;
        else if (cmd_valid && cmd_known && cmd_arg_ok && cmd_kind == CMD_OPEN)
            conn_open <= 1'b1;
        else if (cmd_valid && cmd_known && cmd_arg_ok && cmd_kind == CMD_CLOSE)
            conn_open <= 1'b0; // see R16
    end

    // Master operation tracking and abort on arbitration loss or bus error
    always_ff @(posedge clk)
    begin
        if (reset || adapter_reset)
        begin
            busy <= 1'b0;
            abort_xfer <= 1'b0;
        end
        else
        begin
            abort_xfer <= fault; // see R1
            if (master_ok)
                busy <= 1'b1;
            else if (op_done || fault)
                busy <= 1'b0;
        end
    end

    // Command hand-off pulses to the engines
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            master_start <= 1'b0;
            slave_text_go <= 1'b0;
            cmd_go <= 1'b0;
        end
        else
        begin
            master_start <= master_ok; // see R7, R14
            slave_text_go <= scmd && str_pending; // see R10
            cmd_go <= cmd_valid && cmd_known && cmd_arg_ok && cmd_kind != CMD_MASTER
                      && cmd_kind != CMD_SLAVE_TEXT;
        end
    end

    // Millisecond tick
    always_ff @(posedge clk)
    begin
        if (reset || ms_tick)
            ms_cnt <= '0;
        else
            ms_cnt <= ms_cnt + 1'b1;
    end
    assign ms_tick = (ms_cnt == `ARE_MSDIV_W'(MS_CYCLES - 1));

    // Byte gap timer; reports once per gap and never touches the bus
    always_ff @(posedge clk)
    begin
        if (reset || !msg_active || byte_done)
        begin
            gap_ms <= '0;
            to_reported <= 1'b0;
        end
        else
        begin
            if (ms_tick && gap_ms != `ARE_GAP_MAX)
                gap_ms <= gap_ms + 1'b1;
            if (to_fire)
                to_reported <= 1'b1; // see R6
        end
    end
    assign to_fire = msg_active && !byte_done && !to_reported && (timeout_ms != '0)
                     && (gap_ms > timeout_ms); // see R5

    // Line serializer toward the serial transmitter
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= SER_IDLE;
            cur <= RESP_READY;
            pos <= `ARE_POS_FIRST;
            tx_data <= `ARE_CH_STAR;
            tx_valid <= 1'b0;
        end
        else
        begin
            unique case (state)
                SER_IDLE:
                begin
                    if (|pend)
                    begin
                        state <= SER_SEND;
                        cur <= next_pick;
                        pos <= `ARE_POS_FIRST;
                        tx_data <= are_char(next_pick, `ARE_POS_FIRST, baud_sel);
                        tx_valid <= 1'b1;
                    end
                end
                SER_SEND:
                begin
                    if (tx_ready)
                    begin
                        if (cur == RESP_READY || pos == `ARE_POS_LAST)
                        begin
                            state <= SER_IDLE; // see R16
                            tx_valid <= 1'b0;
                        end
                        else
                        begin
                            pos <= pos + 1'b1;
                            tx_data <= are_char(cur, pos + 1'b1, baud_sel);
                        end
                    end
                end
            endcase
        end
    end

    // Checks
    property p_arb_abort;
        @(posedge clk) disable iff (reset) (arb_lost && busy && !adapter_reset) |=> abort_xfer && !busy;
    endproperty
    a_arb_abort: assert property (p_arb_abort) else $error("arbitration loss not abandoned"); // see R1
    property p_buserr;
        @(posedge clk) disable iff (reset) (bus_error && !adapter_reset) |=> pend[RESP_BUSERR] || state == SER_SEND;
    endproperty
    a_buserr: assert property (p_buserr) else $error("bus error not queued"); // see R3
    property p_to_noabort;
        @(posedge clk) disable iff (reset) (to_fire && !arb_lost && !bus_error) |=> !abort_xfer;
    endproperty
    a_to_noabort: assert property (p_to_noabort) else $error("time-out acted on the bus"); // see R6
    property p_to_report;
        @(posedge clk) disable iff (reset) (msg_active && timeout_ms != '0 && gap_ms > timeout_ms && !byte_done
            && !to_reported && !adapter_reset) |=> pend[RESP_TIMEOUT];
    endproperty
    a_to_report: assert property (p_to_report) else $error("time-out missed"); // see R5
    property p_closed;
        @(posedge clk) disable iff (reset) (mcmd && !conn_open && !adapter_reset) |=> !master_start
            && (pend[RESP_CLOSED] || cur == RESP_CLOSED);
    endproperty
    a_closed: assert property (p_closed) else $error("closed connection not refused"); // see R7
    property p_badarg;
        @(posedge clk) disable iff (reset) (cmd_valid && cmd_known && !cmd_arg_ok && !adapter_reset)
            |=> !master_start && !cmd_go && (pend[RESP_BADARG] || cur == RESP_BADARG);
    endproperty
    a_badarg: assert property (p_badarg) else $error("bad argument accepted"); // see R9
    property p_nostr;
        @(posedge clk) disable iff (reset) (scmd && !str_pending) |=> !slave_text_go;
    endproperty
    a_nostr: assert property (p_nostr) else $error("slave text without request"); // see R10
    property p_badcmd;
        @(posedge clk) disable iff (reset) (cmd_valid && !cmd_known) |=> !cmd_go && !master_start;
    endproperty
    a_badcmd: assert property (p_badcmd) else $error("unknown command accepted"); // see R11
    property p_busy;
        @(posedge clk) disable iff (reset) (mcmd && busy) |=> !master_start;
    endproperty
    a_busy: assert property (p_busy) else $error("busy master command not ignored"); // see R14
    property p_ready;
        @(posedge clk) disable iff (reset) (tx_valid && cur == RESP_READY) |-> tx_data == `ARE_CH_STAR;
    endproperty
    a_ready: assert property (p_ready) else $error("ready prompt not an asterisk"); // see R15
    property p_keep;
        @(posedge clk) disable iff (reset) (cmd_valid && (!cmd_known || !cmd_arg_ok) && !adapter_reset)
            |=> $stable(conn_open);
    endproperty
    a_keep: assert property (p_keep) else $error("rejected command changed state"); // see R16
    property p_baud;
        @(posedge clk) disable iff (reset) baud_change |=> baud_sel == $past(baud_idx);
    endproperty
    a_baud: assert property (p_baud) else $error("rate index not kept"); // see R13
endmodule : are_reporter
`default_nettype wire

// File: bench/are_host_model.sv
// Host model: serial receiver of response characters, with a stall knob.
// Assumes the reporter's tx_valid/tx_ready handshake on the same clock.
`timescale 1ns/100ps
`default_nettype none
module are_host_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic slow,
    output logic tx_ready
);
    logic [7:0] rxq[$];
    logic [1:0] div;
    // Ready every cycle, or one cycle in three while stalling
    always @(posedge clk)
    begin
        div <= (reset || div == 2'h2) ? 2'h0 : div + 2'h1;
        tx_ready <= !reset && (!slow || div == 2'h2);
    end
    // Take a character at each handshake edge
    always @(posedge clk)
    begin
        if (!reset && tx_valid && tx_ready)
        begin
            rxq.push_back(tx_data);
        end
    end
endmodule : are_host_model
`default_nettype wire

// File: bench/tb_are_reporter.sv
// Testbench of the response reporter: host commands, bus events, replies.
// Assumes are_pkg, are_regs.svh and the host model are compiled first.
`include "are_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_are_reporter;
    import are_pkg::*;
    localparam int MS = 10;
    logic clk, reset, cmd_valid, cmd_known, cmd_arg_ok, str_pending, op_done;
    logic arb_lost, bus_error, msg_active, byte_done, rx_overflow, baud_change;
    logic adapter_reset, slow, tx_ready, tx_valid, master_start, slave_text_go;
    logic cmd_go, abort_xfer, conn_open, busy, abort_seen;
    logic [`ARE_GAP_W-1:0] timeout_ms;
    logic [1:0] baud_idx;
    logic [7:0] tx_data;
    are_cmd_t cmd_kind;
    int fail_count, total_checks, cycles;

    are_reporter #(.MS_CYCLES(MS)) u_are_reporter (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_known(cmd_known), .cmd_arg_ok(cmd_arg_ok), .str_pending(str_pending),
        .op_done(op_done), .arb_lost(arb_lost), .bus_error(bus_error), .msg_active(msg_active),
        .byte_done(byte_done), .timeout_ms(timeout_ms), .rx_overflow(rx_overflow),
        .baud_change(baud_change), .baud_idx(baud_idx), .adapter_reset(adapter_reset),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .master_start(master_start),
        .slave_text_go(slave_text_go), .cmd_go(cmd_go), .abort_xfer(abort_xfer),
        .conn_open(conn_open), .busy(busy));
    are_host_model u_are_host_model (.clk(clk), .reset(reset), .tx_data(tx_data),
        .tx_valid(tx_valid), .slow(slow), .tx_ready(tx_ready));

    task automatic final_report();
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask : cmp8

    task automatic cmp1(input string what, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %b got %b", what, e, g);
        end
    endtask : cmp1

    // Wait a bounded time for the next received character
    task automatic take(input logic [7:0] e);
        int n;
        logic [7:0] c;
        n = 0;
        c = 8'h00;
        while (u_are_host_model.rxq.size() == 0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (u_are_host_model.rxq.size() != 0)
            c = u_are_host_model.rxq.pop_front();
        cmp8("line char", e, c);
    endtask : take

    task automatic exp_line(input string s, input bit cr);
        for (int i = 0; i < s.len(); i++)
            take(s[i]);
        if (cr)
            take(8'h0D);
    endtask : exp_line

    task automatic quiet(input int cyc);
        repeat (cyc) @(posedge clk);
        #1;
        cmp1("tx_valid", 1'b0, tx_valid);
        cmp8("extra chars", 8'h00, 8'(u_are_host_model.rxq.size()));
    endtask : quiet

    task automatic issue(input are_cmd_t k, input logic kn, input logic ok);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_known <= kn;
        cmd_arg_ok <= ok;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
    endtask : issue

    // One-cycle pulse: 0 done, 1 arb, 2 bus error, 3 overflow, 4 baud, 5 reset
    task automatic ev(input int w);
        @(posedge clk);
        case (w)
            0: op_done <= 1'b1;
            1: arb_lost <= 1'b1;
            2: bus_error <= 1'b1;
            3: rx_overflow <= 1'b1;
            4: baud_change <= 1'b1;
            default: adapter_reset <= 1'b1;
        endcase
        @(posedge clk);
        {op_done, arb_lost, bus_error, rx_overflow, baud_change, adapter_reset} <= 6'h00;
        #1;
    endtask : ev

    task automatic s_refusals();
        are_cmd_t rk[4] = '{CMD_OTHER, CMD_OTHER, CMD_MASTER, CMD_SLAVE_TEXT};
        logic rn[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
        logic ra[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        string rs[4] = '{"/I8F", "/I89", "/I88", "/I8A"};
        for (int i = 0; i < 4; i++)
        begin
            slow <= i[0];
            issue(rk[i], rn[i], ra[i]);
            cmp1("accepted", 1'b0, master_start | slave_text_go | cmd_go);
            exp_line(rs[i], 1'b1);
            exp_line("*", 1'b0);
            cmp1("conn_open", 1'b0, conn_open);
        end
    endtask : s_refusals

    task automatic s_master();
        issue(CMD_OPEN, 1'b1, 1'b1);
        cmp1("cmd_go", 1'b1, cmd_go);
        exp_line("*", 1'b0);
        issue(CMD_MASTER, 1'b1, 1'b1);
        cmp1("master_start", 1'b1, master_start);
        cmp1("busy", 1'b1, busy);
        issue(CMD_MASTER, 1'b1, 1'b1);
        cmp1("master_start", 1'b0, master_start);
        exp_line("/I81", 1'b1);
        exp_line("*", 1'b0);
        ev(1);
        cmp1("abort_xfer", 1'b1, abort_xfer);
        cmp1("busy", 1'b0, busy);
        exp_line("/I83", 1'b1);
        exp_line("*", 1'b0);
        issue(CMD_MASTER, 1'b1, 1'b1);
        cmp1("master_start", 1'b1, master_start);
        ev(2);
        cmp1("abort_xfer", 1'b1, abort_xfer);
        exp_line("/I84", 1'b1);
        exp_line("*", 1'b0);
        cmp1("conn_open", 1'b1, conn_open);
        issue(CMD_MASTER, 1'b1, 1'b1);
        ev(0);
        cmp1("busy", 1'b0, busy);
        exp_line("*", 1'b0);
        ev(1);
        cmp1("abort_xfer", 1'b0, abort_xfer);
        str_pending <= 1'b1;
        issue(CMD_SLAVE_TEXT, 1'b1, 1'b1);
        cmp1("slave_text_go", 1'b1, slave_text_go);
        ev(0);
        exp_line("*", 1'b0);
        str_pending <= 1'b0;
        quiet(20);
    endtask : s_master

    task automatic s_timeout();
        slow <= 1'b1;
        timeout_ms <= 15'h0002;
        msg_active <= 1'b1;
        repeat (18) @(posedge clk);
        byte_done <= 1'b1;
        @(posedge clk);
        byte_done <= 1'b0;
        quiet(15);
        exp_line("/I85", 1'b1);
        quiet(60);
        cmp1("abort on time-out", 1'b0, abort_seen);
        cmp1("busy", 1'b0, busy);
        msg_active <= 1'b0;
    endtask : s_timeout

    task automatic s_overflow_baud();
        ev(3);
        exp_line("/I90", 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            baud_idx <= i[1:0];
            ev(4);
            exp_line($sformatf("/BC%0d", i), 1'b1);
        end
        quiet(20);
    endtask : s_overflow_baud

    task automatic s_reset_cmd();
        issue(CMD_MASTER, 1'b1, 1'b1);
        ev(5);
        cmp1("conn_open", 1'b0, conn_open);
        cmp1("busy", 1'b0, busy);
    endtask : s_reset_cmd

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Note abort pulses while a bus message runs, and cut a hung run short
    always @(posedge clk)
    begin
        abort_seen <= msg_active && (abort_seen || abort_xfer);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            final_report();
        end
    end

    initial
    begin
        {reset, slow} = 2'b10;
        {cmd_valid, cmd_known, cmd_arg_ok, str_pending, op_done, arb_lost} = 6'h00;
        {bus_error, msg_active, byte_done, rx_overflow, baud_change, adapter_reset} = 6'h00;
        cmd_kind = CMD_OTHER;
        {timeout_ms, baud_idx} = 17'h00000;
        {fail_count, total_checks, cycles} = '0;
        abort_seen = 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1;
        cmp1("tx_valid", 1'b0, tx_valid);
        cmp8("tx_data", 8'h2A, tx_data);
        cmp1("conn_open", 1'b0, conn_open);
        s_refusals();
        s_master();
        s_timeout();
        s_overflow_baud();
        s_reset_cmd();
        final_report();
    end
endmodule : tb_are_reporter
`default_nettype wire
